// *** inc/ald_pkg.sv ***
// shared constants and types for the arithmetic/logic opcode decoder
package ald_pkg;

	// decoded operation classes
	typedef enum logic [3:0] {
		K_NONE, K_SMUL, K_SMUL_IMM, K_UDIV, K_SDIV, K_ADJ_MUL, K_ADJ_DIV,
		K_BYTE_SEXT, K_WORD_SEXT, K_SHIFT, K_AND, K_TEST, K_OR
	} ald_kind_t;

	// operand forms
	typedef enum logic [2:0] {
		F_IMPLIED, F_RM_REG, F_RM_IMM, F_ACC_IMM, F_SH_ONE, F_SH_CNT, F_SH_IMM
	} ald_form_t;

	// byte collection, load and run states
	typedef enum logic [2:0] {
		S_OP, S_MODRM, S_SECOND, S_DISP, S_IMM, S_LOAD, S_RUN
	} ald_state_t;

	// opcode classification
	typedef struct packed {
		ald_kind_t kind;
		ald_form_t form;
		logic has_modrm;
		logic second;
		logic [1:0] imm_len;
		logic legal;
	} ald_cls_t;

	// decoded instruction handed to the datapath
	typedef struct packed {
		ald_kind_t kind;
		ald_form_t form;
		logic word;
		logic dir;
		logic mem;
		logic [1:0] mod_f;
		logic [2:0] reg_f;
		logic [2:0] rm_f;
		logic [15:0] disp;
		logic [15:0] imm;
		logic [8:0] cycles;
	} ald_dec_t;

	////////////////////////////////////////////////////////////////////////
	// execution cycle counts
	localparam logic [8:0] C_SMUL_RB = 9'h019;
	localparam logic [8:0] C_SMUL_RW = 9'h022;
	localparam logic [8:0] C_SMUL_MB = 9'h01f;
	localparam logic [8:0] C_SMUL_MW = 9'h028;
	localparam logic [3:0] SPAN_SMUL = 4'h3;
	localparam logic [8:0] C_SIGNED_MULTIPLY_R = 9'h016;
	localparam logic [8:0] C_SIGNED_MULTIPLY_M = 9'h01d;
	localparam logic [8:0] C_UDIV_RB = 9'h01d;
	localparam logic [8:0] C_UDIV_RW = 9'h026;
	localparam logic [8:0] C_UDIV_MB = 9'h023;
	localparam logic [8:0] C_UDIV_MW = 9'h02c;
	localparam logic [8:0] C_SDIV_RB = 9'h02c;
	localparam logic [8:0] C_SDIV_RW = 9'h035;
	localparam logic [8:0] C_SDIV_MB = 9'h032;
	localparam logic [8:0] C_SDIV_MW = 9'h03b;
	localparam logic [3:0] SPAN_SDIV = 4'h8;
	localparam logic [8:0] C_ADJ_MUL = 9'h013;
	localparam logic [8:0] C_ADJ_DIV = 9'h00f;
	localparam logic [8:0] C_BSEXT = 9'h002;
	localparam logic [8:0] C_WSEXT = 9'h004;
	localparam logic [8:0] C_SH1_R = 9'h002;
	localparam logic [8:0] C_SH1_M = 9'h00f;
	localparam logic [8:0] C_SHN_R = 9'h005;
	localparam logic [8:0] C_SHN_M = 9'h011;
	localparam logic [8:0] C_LOG_RR = 9'h003;
	localparam logic [8:0] C_LOG_RM = 9'h00a;
	localparam logic [8:0] C_LOG_IR = 9'h004;
	localparam logic [8:0] C_LOG_IM = 9'h010;
	localparam logic [8:0] C_TEST_IM = 9'h00a;
	localparam logic [8:0] C_ACC_B = 9'h003;
	localparam logic [8:0] C_ACC_W = 9'h004;
	localparam logic [8:0] C_NARROW_ADD = 9'h004;
	localparam logic [8:0] C_IDLE = 9'h001;

	// fixed second byte of the decimal adjust pair
	localparam logic [7:0] ADJ_SECOND = 8'h0a;
	// reset and idle value of the execution cycle down-counter
	localparam logic [8:0] RST_CYCLES = 9'h000;

endpackage : ald_pkg

// *** logic/ald_opclass.sv ***
// opcode and modrm reg field classification
`timescale 1ns/100ps
module ald_opclass (
	// opcode and reg field
	input wire logic [7:0] op_in,
	input wire logic [2:0] reg_in,
	// classification
	output ald_pkg::ald_cls_t cls_out
);

	always_comb begin
		cls_out.kind = ald_pkg::K_NONE;
		cls_out.form = ald_pkg::F_IMPLIED;
		cls_out.has_modrm = 1'b0;
		cls_out.second = 1'b0;
		cls_out.imm_len = 2'h0;
		cls_out.legal = 1'b1;
		if (op_in[7:1] == 7'h7b) begin
			cls_out.has_modrm = 1'b1;
			cls_out.form = ald_pkg::F_RM_REG;
			unique case (reg_in)
				3'h0: begin
					cls_out.kind = ald_pkg::K_TEST;
					cls_out.form = ald_pkg::F_RM_IMM;
					cls_out.imm_len = op_in[0] ? 2'h2 : 2'h1;
				end
				3'h5: cls_out.kind = ald_pkg::K_SMUL;
				3'h6: cls_out.kind = ald_pkg::K_UDIV;
				3'h7: cls_out.kind = ald_pkg::K_SDIV;
				default: cls_out.legal = 1'b0;
			endcase
		end else if (op_in[7:2] == 6'h1a && op_in[0]) begin
			cls_out.kind = ald_pkg::K_SMUL_IMM;
			cls_out.form = ald_pkg::F_RM_IMM;
			cls_out.has_modrm = 1'b1;
			cls_out.imm_len = op_in[1] ? 2'h1 : 2'h2;
		end else if (op_in == 8'hd4) begin
			cls_out.kind = ald_pkg::K_ADJ_MUL;
			cls_out.second = 1'b1;
		end else if (op_in == 8'hd5) begin
			cls_out.kind = ald_pkg::K_ADJ_DIV;
			cls_out.second = 1'b1;
		end else if (op_in == 8'h98) begin
			cls_out.kind = ald_pkg::K_BYTE_SEXT;
		end else if (op_in == 8'h99) begin
			cls_out.kind = ald_pkg::K_WORD_SEXT;
		end else if (op_in[7:2] == 6'h34) begin
			cls_out.kind = ald_pkg::K_SHIFT;
			cls_out.has_modrm = 1'b1;
			cls_out.form = op_in[1] ? ald_pkg::F_SH_CNT : ald_pkg::F_SH_ONE;
			cls_out.legal = reg_in != 3'h6;
		end else if (op_in[7:1] == 7'h60) begin
			cls_out.kind = ald_pkg::K_SHIFT;
			cls_out.has_modrm = 1'b1;
			cls_out.form = ald_pkg::F_SH_IMM;
			cls_out.imm_len = 2'h1;
			cls_out.legal = reg_in != 3'h6;
		end else if (op_in[7:2] == 6'h08) begin
			cls_out.kind = ald_pkg::K_AND;
			cls_out.form = ald_pkg::F_RM_REG;
			cls_out.has_modrm = 1'b1;
		end else if (op_in[7:1] == 7'h40) begin
			cls_out.has_modrm = 1'b1;
			cls_out.form = ald_pkg::F_RM_IMM;
			cls_out.imm_len = op_in[0] ? 2'h2 : 2'h1;
			unique case (reg_in)
				3'h4: cls_out.kind = ald_pkg::K_AND;
				3'h1: cls_out.kind = ald_pkg::K_OR;
				default: cls_out.legal = 1'b0;
			endcase
		end else if (op_in[7:1] == 7'h12 || op_in[7:1] == 7'h54 || op_in[7:1] == 7'h06) begin
			// accumulator forms: and, test, or
			cls_out.kind = op_in[7:1] == 7'h12 ? ald_pkg::K_AND :
				(op_in[7:1] == 7'h54 ? ald_pkg::K_TEST : ald_pkg::K_OR);
			cls_out.form = ald_pkg::F_ACC_IMM;
			cls_out.imm_len = op_in[0] ? 2'h2 : 2'h1;
		end else if (op_in[7:1] == 7'h42 || op_in[7:2] == 6'h02) begin
			cls_out.kind = op_in[7] ? ald_pkg::K_TEST : ald_pkg::K_OR;
			cls_out.form = ald_pkg::F_RM_REG;
			cls_out.has_modrm = 1'b1;
		end else begin
			cls_out.legal = 1'b0;
		end
	end

endmodule : ald_opclass

// *** logic/ald_cycle_timer.sv ***
// execution cycle down-counter
`timescale 1ns/100ps
module ald_cycle_timer (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// load
	input wire logic load_in,
	input wire logic [8:0] count_in,
	// status
	output logic busy_out,
	output logic done_out
);

	logic [8:0] cnt_reg;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_reg <= ald_pkg::RST_CYCLES;
		end else if (load_in) begin
			cnt_reg <= count_in;
		end else if (cnt_reg != ald_pkg::RST_CYCLES) begin
			cnt_reg <= cnt_reg - 9'h001;
		end
	end

	assign busy_out = cnt_reg != ald_pkg::RST_CYCLES;
	assign done_out = cnt_reg == 9'h001;

endmodule : ald_cycle_timer

// *** logic/ald_opcode_decode.sv ***
// arithmetic/logic opcode decoder with execution timing
//
// Contract
// - f6/f7 reg 101 is signed multiply: reg byte 25-28, reg word 34-37.
// - 011010s1 is immediate signed multiply; second data byte only if s=0.
// - f6/f7 reg 110 is unsigned divide: 29, 38, 35, 44 cycles.
// - f6/f7 reg 111 is signed divide: 44-52, 53-61, 50-58, 59-67 cycles.
// - d4 then 0a is decimal adjust after multiply, 19 cycles.
// - d5 then 0a is decimal adjust before divide, 15 cycles.
// - 98 sign-extends low accumulator byte to word in 2 cycles.
// - 99 sign-extends accumulator word into data register in 4 cycles.
// - shifts come by one, by count register, or by immediate count byte.
// - shift reg field picks rotate, rotate-carry, left, logical or arithmetic right.
// - and: register form 3/10, immediate 4/16, accumulator 3/4.
// - test ands into flags only, never writes a result.
// - or: register form, immediate reg field 001, accumulator form.
// - on the narrow bus, word memory transfers cost 4 more cycles each.
`timescale 1ns/100ps
module ald_opcode_decode (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// prefetch queue
	input wire logic [7:0] q_byte_in,
	input wire logic q_valid_in,
	output logic q_ready_out,
	// datapath status
	input wire logic [7:0] count_reg_in,
	input wire logic [3:0] var_cycles_in,
	// narrow bus strap pin
	input wire logic narrow_bus_in,
	// decoded instruction
	output ald_pkg::ald_dec_t dec_out,
	output logic dec_valid_out,
	output logic busy_out,
	output logic exec_done_out,
	output logic result_write_out,
	// undecoded instruction and the byte that rejected it
	output logic foreign_out,
	output logic [7:0] foreign_byte_out
);

	ald_pkg::ald_state_t state_reg, state_next;
	ald_pkg::ald_cls_t cls;
	ald_pkg::ald_kind_t kind_reg;
	ald_pkg::ald_form_t form_reg;
	ald_pkg::ald_dec_t dec_reg;
	logic [7:0] op_reg;
	logic [7:0] modrm_reg;
	logic modrm_used_reg;
	logic [15:0] disp_reg;
	logic [15:0] imm_reg;
	logic [1:0] imm_len_reg;
	logic [1:0] left_reg;
	logic first_reg;
	logic nb_meta_reg, nb_sync_reg;
	logic dec_valid_reg, foreign_reg;
	logic [7:0] foreign_byte_reg;
	logic take, illegal, load, t_busy, t_done;
	logic [1:0] dl_now, imm_len_now;
	logic [8:0] cyc_next;

	////////////////////////////////////////////////////////////////////////
	// classification and byte intake

	ald_opclass u_class (
		.op_in(state_reg == ald_pkg::S_OP ? q_byte_in : op_reg),
		.reg_in(state_reg == ald_pkg::S_MODRM ? q_byte_in[5:3] : modrm_reg[5:3]),
		.cls_out(cls)
	);

	function automatic logic [1:0] disp_len(input logic [7:0] b);
		if (b[7:6] == 2'h1) begin
			disp_len = 2'h1;
		end else if (b[7:6] == 2'h2 || (b[7:6] == 2'h0 && b[2:0] == 3'h6)) begin
			disp_len = 2'h2;
		end else begin
			disp_len = 2'h0;
		end
	endfunction : disp_len

	assign q_ready_out = state_reg == ald_pkg::S_OP || state_reg == ald_pkg::S_MODRM ||
		state_reg == ald_pkg::S_SECOND || state_reg == ald_pkg::S_DISP ||
		state_reg == ald_pkg::S_IMM;
	assign take = q_valid_in && q_ready_out;
	assign dl_now = disp_len(q_byte_in);
	assign imm_len_now = (state_reg == ald_pkg::S_OP || state_reg == ald_pkg::S_MODRM) ?
		cls.imm_len : imm_len_reg;
	// group legality is only known once the modrm byte is in
	assign illegal = take && ((state_reg == ald_pkg::S_OP && !cls.has_modrm && !cls.legal) ||
		(state_reg == ald_pkg::S_MODRM && !cls.legal) ||
		(state_reg == ald_pkg::S_SECOND && q_byte_in != ald_pkg::ADJ_SECOND));
	assign load = state_reg == ald_pkg::S_LOAD;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ald_pkg::S_OP: if (take && !illegal) begin
				if (cls.has_modrm) begin
					state_next = ald_pkg::S_MODRM;
				end else if (cls.second) begin
					state_next = ald_pkg::S_SECOND;
				end else if (cls.imm_len != 2'h0) begin
					state_next = ald_pkg::S_IMM;
				end else begin
					state_next = ald_pkg::S_LOAD;
				end
			end
			ald_pkg::S_MODRM: if (take) begin
				if (illegal) begin
					state_next = ald_pkg::S_OP;
				end else if (dl_now != 2'h0) begin
					state_next = ald_pkg::S_DISP;
				end else if (cls.imm_len != 2'h0) begin
					state_next = ald_pkg::S_IMM;
				end else begin
					state_next = ald_pkg::S_LOAD;
				end
			end
			ald_pkg::S_SECOND: if (take) begin
				state_next = illegal ? ald_pkg::S_OP : ald_pkg::S_LOAD;
			end
			ald_pkg::S_DISP: if (take && left_reg == 2'h1) begin
				state_next = imm_len_reg != 2'h0 ? ald_pkg::S_IMM : ald_pkg::S_LOAD;
			end
			ald_pkg::S_IMM: if (take && left_reg == 2'h1) begin
				state_next = ald_pkg::S_LOAD;
			end
			ald_pkg::S_LOAD: state_next = ald_pkg::S_RUN;
			ald_pkg::S_RUN: if (t_done) begin
				state_next = ald_pkg::S_OP;
			end
			default: state_next = ald_pkg::S_OP;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= ald_pkg::S_OP;
		end else begin
			state_reg <= state_next;
		end
	end

	// opcode, modrm and class capture
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			op_reg <= 8'h00;
			modrm_reg <= 8'h00;
			modrm_used_reg <= 1'b0;
			kind_reg <= ald_pkg::K_NONE;
			form_reg <= ald_pkg::F_IMPLIED;
			imm_len_reg <= 2'h0;
		end else if (take && (state_reg == ald_pkg::S_OP || state_reg == ald_pkg::S_MODRM)) begin
			if (state_reg == ald_pkg::S_OP) begin
				op_reg <= q_byte_in;
				modrm_used_reg <= cls.has_modrm;
			end else begin
				modrm_reg <= q_byte_in;
			end
			kind_reg <= cls.kind;
			form_reg <= cls.form;
			imm_len_reg <= cls.imm_len;
		end
	end

	// displacement and immediate bytes, low byte first
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			left_reg <= 2'h0;
			first_reg <= 1'b0;
			disp_reg <= 16'h0000;
			imm_reg <= 16'h0000;
		end else if (take && state_reg == ald_pkg::S_OP) begin
			disp_reg <= 16'h0000;
			imm_reg <= 16'h0000;
			left_reg <= imm_len_now;
			first_reg <= 1'b1;
		end else if (take && state_reg == ald_pkg::S_MODRM) begin
			left_reg <= dl_now != 2'h0 ? dl_now : imm_len_now;
			first_reg <= 1'b1;
		end else if (take && state_reg == ald_pkg::S_DISP) begin
			if (first_reg) begin
				disp_reg[7:0] <= q_byte_in;
			end else begin
				disp_reg[15:8] <= q_byte_in;
			end
			left_reg <= left_reg == 2'h1 ? imm_len_reg : left_reg - 2'h1;
			first_reg <= left_reg == 2'h1;
		end else if (take && state_reg == ald_pkg::S_IMM) begin
			if (first_reg) begin
				imm_reg[7:0] <= q_byte_in;
			end else begin
				imm_reg[15:8] <= q_byte_in;
			end
			left_reg <= left_reg - 2'h1;
			first_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strap synchroniser, pin is not on the core clock

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			nb_meta_reg <= 1'b0;
			nb_sync_reg <= 1'b0;
		end else begin
			nb_meta_reg <= narrow_bus_in;
			nb_sync_reg <= nb_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execution cycle count

	always_comb begin
		logic mem, word, rmw;
		logic [8:0] base, extra, n;
		logic [3:0] span, var_n;
		mem = modrm_used_reg && modrm_reg[7:6] != 2'h3;
		word = op_reg[0];
		// register destination of the d form only reads memory once
		rmw = kind_reg == ald_pkg::K_SHIFT || ((kind_reg == ald_pkg::K_AND ||
			kind_reg == ald_pkg::K_OR) && !(form_reg == ald_pkg::F_RM_REG && op_reg[1]));
		n = form_reg == ald_pkg::F_SH_CNT ? {1'b0, count_reg_in} : {1'b0, imm_reg[7:0]};
		span = 4'h0;
		base = ald_pkg::C_IDLE;
		unique case (kind_reg)
			ald_pkg::K_SMUL: begin
				base = mem ? (word ? ald_pkg::C_SMUL_MW : ald_pkg::C_SMUL_MB) :
					(word ? ald_pkg::C_SMUL_RW : ald_pkg::C_SMUL_RB);
				span = ald_pkg::SPAN_SMUL;
			end
			ald_pkg::K_SMUL_IMM: begin
				base = mem ? ald_pkg::C_SIGNED_MULTIPLY_M : ald_pkg::C_SIGNED_MULTIPLY_R;
				span = ald_pkg::SPAN_SMUL;
			end
			ald_pkg::K_UDIV: base = mem ? (word ? ald_pkg::C_UDIV_MW : ald_pkg::C_UDIV_MB) :
				(word ? ald_pkg::C_UDIV_RW : ald_pkg::C_UDIV_RB);
			ald_pkg::K_SDIV: begin
				base = mem ? (word ? ald_pkg::C_SDIV_MW : ald_pkg::C_SDIV_MB) :
					(word ? ald_pkg::C_SDIV_RW : ald_pkg::C_SDIV_RB);
				span = ald_pkg::SPAN_SDIV;
			end
			ald_pkg::K_ADJ_MUL: base = ald_pkg::C_ADJ_MUL;
			ald_pkg::K_ADJ_DIV: base = ald_pkg::C_ADJ_DIV;
			ald_pkg::K_BYTE_SEXT: base = ald_pkg::C_BSEXT;
			ald_pkg::K_WORD_SEXT: base = ald_pkg::C_WSEXT;
			ald_pkg::K_SHIFT: base = form_reg == ald_pkg::F_SH_ONE ?
				(mem ? ald_pkg::C_SH1_M : ald_pkg::C_SH1_R) :
				(mem ? ald_pkg::C_SHN_M : ald_pkg::C_SHN_R) + n;
			default: begin
				// and, test, or
				if (form_reg == ald_pkg::F_ACC_IMM) begin
					base = word ? ald_pkg::C_ACC_W : ald_pkg::C_ACC_B;
				end else if (form_reg == ald_pkg::F_RM_REG) begin
					base = mem ? ald_pkg::C_LOG_RM : ald_pkg::C_LOG_RR;
				end else if (kind_reg == ald_pkg::K_TEST) begin
					base = mem ? ald_pkg::C_TEST_IM : ald_pkg::C_LOG_IR;
				end else if (kind_reg != ald_pkg::K_NONE) begin
					base = mem ? ald_pkg::C_LOG_IM : ald_pkg::C_LOG_IR;
				end
			end
		endcase
		// data-dependent part comes from the datapath, clamped to the range span
		var_n = var_cycles_in > span ? span : var_cycles_in;
		extra = (nb_sync_reg && word && mem) ?
			(rmw ? ald_pkg::C_NARROW_ADD + ald_pkg::C_NARROW_ADD : ald_pkg::C_NARROW_ADD) :
			9'h000;
		cyc_next = base + {5'h00, var_n} + extra;
	end

	ald_cycle_timer u_timer (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.load_in(load),
		.count_in(cyc_next),
		.busy_out(t_busy),
		.done_out(t_done)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dec_reg <= '0;
			dec_valid_reg <= 1'b0;
		end else begin
			dec_valid_reg <= load;
			if (load) begin
				dec_reg.kind <= kind_reg;
				dec_reg.form <= form_reg;
				dec_reg.word <= op_reg[0];
				dec_reg.dir <= form_reg == ald_pkg::F_RM_REG && op_reg[1];
				dec_reg.mem <= modrm_used_reg && modrm_reg[7:6] != 2'h3;
				dec_reg.mod_f <= modrm_reg[7:6];
				dec_reg.reg_f <= modrm_reg[5:3];
				dec_reg.rm_f <= modrm_reg[2:0];
				dec_reg.disp <= disp_reg;
				dec_reg.imm <= imm_reg;
				dec_reg.cycles <= cyc_next;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			foreign_reg <= 1'b0;
			foreign_byte_reg <= 8'h00;
		end else begin
			foreign_reg <= illegal;
			if (illegal) begin
				foreign_byte_reg <= q_byte_in;
			end
		end
	end

	assign dec_out = dec_reg;
	assign dec_valid_out = dec_valid_reg;
	assign busy_out = t_busy;
	assign exec_done_out = t_done;
	assign result_write_out = t_done && dec_reg.kind != ald_pkg::K_TEST;
	assign foreign_out = foreign_reg;
	assign foreign_byte_out = foreign_byte_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_smul_reg_time: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_SMUL && !dec_out.mem |->
		dec_out.cycles >= (dec_out.word ? 9'h022 : 9'h019) &&
		dec_out.cycles <= (dec_out.word ? 9'h025 : 9'h01c))
		else $error("signed multiply cycle count out of range");

	chk_signed_multiply_imm_time: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_SMUL_IMM && !dec_out.mem |->
		dec_out.cycles inside {[9'h016:9'h019]})
		else $error("immediate multiply cycle count out of range");

	chk_udiv_reg_time: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_UDIV && !dec_out.mem |->
		##(0) dec_out.cycles == (dec_out.word ? 9'h026 : 9'h01d))
		else $error("unsigned divide cycle count wrong");

	chk_sdiv_span: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_SDIV && !dec_out.mem && !dec_out.word |->
		dec_out.cycles inside {[9'h02c:9'h034]})
		else $error("signed divide cycle count out of range");

	chk_adjust_done: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_ADJ_MUL |->
		!exec_done_out [*8] ##11 exec_done_out ##1 q_ready_out)
		else $error("adjust after multiply did not finish in 19 cycles");

	chk_sext_done: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_BYTE_SEXT |-> ##1 exec_done_out)
		else $error("byte sign extend did not finish in 2 cycles");

	chk_shift_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_SHIFT && dec_out.form == ald_pkg::F_SH_CNT &&
		!dec_out.mem |-> dec_out.cycles == 9'h005 + {1'b0, $past(count_reg_in)})
		else $error("shift by count register cycle count wrong");

	chk_shift_field: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_SHIFT |-> dec_out.reg_f != 3'h6)
		else $error("undefined shift operation decoded");

	chk_test_no_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		busy_out && dec_out.kind == ald_pkg::K_TEST |-> !result_write_out)
		else $error("flag-only and wrote a result");

	chk_narrow_add: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dec_valid_out && dec_out.kind == ald_pkg::K_UDIV && dec_out.mem && dec_out.word |->
		dec_out.cycles == ($past(nb_sync_reg) ? 9'h030 : 9'h02c))
		else $error("narrow bus word memory penalty wrong");

endmodule : ald_opcode_decode

// *** bench/ald_queue_model.sv ***
// prefetch queue model feeding the decoder one byte at a time
`timescale 1ns/100ps
module ald_queue_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// handshake
	input wire logic ready_in,
	input wire logic slow_in,
	output logic [7:0] byte_out,
	output logic valid_out
);
	logic [7:0] q[$];
	logic gap;
	initial begin
		byte_out = 8'h00;
		valid_out = 1'b0;
		gap = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// pop on the taking edge; slow mode idles one cycle after each byte
	always @(posedge clk_in) begin
		if (valid_out && ready_in) begin
			q.delete(0);
			gap = slow_in;
		end
	end
	// bytes go out in pushed order, low byte of 16-bit fields first
	always @(negedge clk_in) begin
		if (!rst_b_in || q.size() == 0 || gap) begin
			valid_out <= 1'b0;
			byte_out <= ~byte_out;
			gap = 1'b0;
		end else begin
			valid_out <= 1'b1;
			byte_out <= q[0];
		end
	end
endmodule : ald_queue_model

// *** bench/testbench.sv ***
// self-checking bench for the opcode decoder
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module testbench;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] cnt = 8'h00;
	logic [3:0] var_c = 4'h0;
	logic narrow = 1'b0;
	logic slow = 1'b0;
	logic [7:0] q_byte;
	logic [7:0] f_byte;
	logic q_valid, q_ready, dec_valid, busy, done, wr, foreign;
	ald_pkg::ald_dec_t dec;
	int fail_count = 0;
	int checked = 0;
	always #5 clk_in = ~clk_in;
	ald_queue_model qm (.clk_in(clk_in), .rst_b_in(rst_b_in), .ready_in(q_ready),
		.slow_in(slow), .byte_out(q_byte), .valid_out(q_valid));
	ald_opcode_decode dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .q_byte_in(q_byte),
		.q_valid_in(q_valid), .q_ready_out(q_ready), .count_reg_in(cnt),
		.var_cycles_in(var_c), .narrow_bus_in(narrow), .dec_out(dec),
		.dec_valid_out(dec_valid), .busy_out(busy), .exec_done_out(done),
		.result_write_out(wr), .foreign_out(foreign), .foreign_byte_out(f_byte));
	////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// waits bounded; done must land in the c-th busy cycle, counting the first busy cycle as one
	task ex(input ald_pkg::ald_kind_t k, input logic [8:0] c, input logic w);
		int n;
		n = 0;
		while (dec_valid !== 1'b1) begin
			@(negedge clk_in);
			n++;
			if (n > 400) begin
				fail_count++;
				close_out();
			end
		end
		`CHK("kind", k, dec.kind)
		`CHK("cycles", c, dec.cycles)
		n = 1;
		while (done !== 1'b1) begin
			`CHK("busy", 1'b1, busy)
			@(negedge clk_in);
			n++;
			if (n > 400) begin
				fail_count++;
				close_out();
			end
		end
		`CHK("busy len", c, n[8:0])
		`CHK("write", w, wr)
		@(negedge clk_in);
		`CHK("busy off", 1'b0, busy)
	endtask : ex
	task fo(input logic [7:0] b);
		int n;
		n = 0;
		while (foreign !== 1'b1) begin
			@(negedge clk_in);
			n++;
			if (n > 100) begin
				fail_count++;
				close_out();
			end
		end
		`CHK("foreign byte", b, f_byte)
		@(negedge clk_in);
	endtask : fo
	////////////////////////////////////////////////////////////////////////
	task t_sext;
		// back to back: second opcode must wait out the first
		qm.q = '{8'h98, 8'h99};
		ex(ald_pkg::K_BYTE_SEXT, 9'h002, 1'b1);
		ex(ald_pkg::K_WORD_SEXT, 9'h004, 1'b1);
		$display("t_sext done");
	endtask : t_sext
	task t_muldiv;
		qm.q = '{8'hf6, 8'he8};
		ex(ald_pkg::K_SMUL, 9'h019, 1'b1);
		var_c = 4'h9;
		qm.q = '{8'hf7, 8'he9, 8'hf7, 8'hf8};
		ex(ald_pkg::K_SMUL, 9'h025, 1'b1);
		ex(ald_pkg::K_SDIV, 9'h03d, 1'b1);
		var_c = 4'h0;
		qm.q = '{8'hf6, 8'hf0, 8'hf7, 8'hf0, 8'hf6, 8'h36, 8'h00, 8'h10, 8'hf6, 8'hf8};
		ex(ald_pkg::K_UDIV, 9'h01d, 1'b1);
		ex(ald_pkg::K_UDIV, 9'h026, 1'b1);
		ex(ald_pkg::K_UDIV, 9'h023, 1'b1);
		ex(ald_pkg::K_SDIV, 9'h02c, 1'b1);
		qm.q = '{8'h6b, 8'hc0, 8'h05, 8'h69, 8'hc0, 8'h34, 8'h12};
		ex(ald_pkg::K_SMUL_IMM, 9'h016, 1'b1);
		`CHK("imm8", 16'h0005, dec.imm)
		ex(ald_pkg::K_SMUL_IMM, 9'h016, 1'b1);
		`CHK("imm16", 16'h1234, dec.imm)
		$display("t_muldiv done");
	endtask : t_muldiv
	task t_adj;
		qm.q = '{8'hd4, 8'h0a, 8'hd5, 8'h0a, 8'hd4, 8'h0b};
		ex(ald_pkg::K_ADJ_MUL, 9'h013, 1'b1);
		ex(ald_pkg::K_ADJ_DIV, 9'h00f, 1'b1);
		fo(8'h0b);
		$display("t_adj done");
	endtask : t_adj
	task t_shift;
		cnt = 8'h03;
		for (int r = 0; r < 8; r++) begin
			qm.q = '{8'hd0, 8'hc0 | 8'(r << 3)};
			if (r == 6) begin
				fo(8'hf0);
			end else begin
				ex(ald_pkg::K_SHIFT, 9'h002, 1'b1);
				`CHK("op field", 3'(r), dec.reg_f)
			end
		end
		qm.q = '{8'hd3, 8'he0, 8'hc1, 8'he8, 8'h04};
		ex(ald_pkg::K_SHIFT, 9'h008, 1'b1);
		ex(ald_pkg::K_SHIFT, 9'h009, 1'b1);
		`CHK("form", ald_pkg::F_SH_IMM, dec.form)
		$display("t_shift done");
	endtask : t_shift
	task t_logic;
		slow = 1'b1;
		qm.q = '{8'h20, 8'hc0, 8'h24, 8'h05, 8'h25, 8'h34, 8'h12, 8'h80, 8'he0, 8'h05};
		ex(ald_pkg::K_AND, 9'h003, 1'b1);
		ex(ald_pkg::K_AND, 9'h003, 1'b1);
		ex(ald_pkg::K_AND, 9'h004, 1'b1);
		ex(ald_pkg::K_AND, 9'h004, 1'b1);
		qm.q = '{8'h84, 8'hc0, 8'ha8, 8'h05, 8'h08, 8'hc0, 8'h81, 8'hc8, 8'h34, 8'h12};
		ex(ald_pkg::K_TEST, 9'h003, 1'b0);
		ex(ald_pkg::K_TEST, 9'h003, 1'b0);
		ex(ald_pkg::K_OR, 9'h003, 1'b1);
		ex(ald_pkg::K_OR, 9'h004, 1'b1);
		slow = 1'b0;
		qm.q = '{8'h0c, 8'h05, 8'h20, 8'h06, 8'h00, 8'h10, 8'h22, 8'hc1};
		ex(ald_pkg::K_OR, 9'h003, 1'b1);
		ex(ald_pkg::K_AND, 9'h00a, 1'b1);
		`CHK("mem", 1'b1, dec.mem)
		`CHK("disp", 16'h1000, dec.disp)
		ex(ald_pkg::K_AND, 9'h003, 1'b1);
		`CHK("dir", 1'b1, dec.dir)
		$display("t_logic done");
	endtask : t_logic
	task t_narrow;
		narrow = 1'b1;
		repeat (3) @(negedge clk_in);
		qm.q = '{8'hf6, 8'h36, 8'h00, 8'h10, 8'hf7, 8'h36, 8'h00, 8'h10,
			8'hd1, 8'h26, 8'h00, 8'h10};
		ex(ald_pkg::K_UDIV, 9'h023, 1'b1);
		ex(ald_pkg::K_UDIV, 9'h030, 1'b1);
		`CHK("word", 1'b1, dec.word)
		ex(ald_pkg::K_SHIFT, 9'h017, 1'b1);
		narrow = 1'b0;
		$display("t_narrow done");
	endtask : t_narrow
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge clk_in);
		rst_b_in = 1'b1;
		`CHK("ready after reset", 1'b1, q_ready)
		t_sext();
		t_muldiv();
		t_adj();
		t_shift();
		t_logic();
		t_narrow();
		close_out();
	end
endmodule : testbench
